// ===== hdl/mas_defs.vh
// Constants for the multi converter sample scheduler
`ifndef MAS_DEFS_VH
`define MAS_DEFS_VH
// ----------------------------------------
// Trigger source codes
// ----------------------------------------
`define MAS_TRG_NONE 3'h0
`define MAS_TRG_PFC_A 3'h1
`define MAS_TRG_PFC_B 3'h2
`define MAS_TRG_PH2_A 3'h3
`define MAS_TRG_PH2_B 3'h4
`define MAS_TRG_PRIM_A 3'h5
`define MAS_TRG_TMR2 3'h6
// ----------------------------------------
// Channel numbers
// ----------------------------------------
`define MAS_CH_A2 5'h02
`define MAS_CH_A4 5'h04
`define MAS_CH_A5 5'h05
`define MAS_CH_A9 5'h09
`define MAS_CH_A11 5'h0b
`define MAS_CH_B2 5'h02
`define MAS_CH_B4 5'h04
`define MAS_CH_B5 5'h05
`define MAS_CH_B12 5'h0c
`define MAS_CH_C7 5'h07
`define MAS_CH_C10 5'h0a
`define MAS_CH_C11 5'h0b
// ----------------------------------------
// Converter identities and sizes
// ----------------------------------------
`define MAS_CONV_A 2'h0
`define MAS_CONV_B 2'h1
`define MAS_CONV_C 2'h2
`define MAS_NUM_SLOTS 16
`define MAS_FIFO_DEPTH 16
`define MAS_RESULT_RST 12'h000
`endif

// ===== hdl/mas_fifo.v
// Parameterised valid/ready FIFO for sample records
`timescale 1ns/1ns
module mas_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  // Depth sized to the counter so the full compare keeps its width
  localparam [AW:0] DEPTH_W = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg oreg_q;
  wire push;
  wire pop_mem;
  wire take;
  assign in_ready = (cnt_q != DEPTH_W);
  assign push = in_valid && in_ready;
  assign out_valid = oreg_q;
  assign take = oreg_q && out_ready;
  // Output register refilled when empty or drained
  assign pop_mem = (cnt_q != {(AW+1){1'b0}}) && (!oreg_q || take);
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (pop_mem) begin
      out_data <= mem[rd_q];
    end
  end
  always @(posedge sys_clk) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      oreg_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop_mem) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
      if (pop_mem) begin
        oreg_q <= 1'b1;
      end else if (take) begin
        oreg_q <= 1'b0;
      end
    end
  end
endmodule // mas_fifo

// ===== hdl/mas_sched.v
// One converter's slot scheduler, three instances in the top
// Operation
// R1: Three converters sequence fully independently
// R2: One sample per slot per trigger firing
// R3: Pending slots served round robin ascending
// R4: PFC trigger pair fires A and B each period
// R5: Converter A slots 0/1 phase-one current
// R6: Converter B slots 0/1 phase-two current B12
// R7: Converter C slots 0/1 line voltage C7
// R8: Converter A A5 slots 2-12 eleven samples
// R9: Converter C C11 slots 2-12 trigger A
// R10: Converter B B4 slots 2-5, two PWMs
// R11: Converter A A9 slot 13 primary trigger
// R12: Low-rate slots on timer trigger, placed last
// R13: Converter A A4 slot 14, A11 slot 15
// R14: Tank currents never mapped to slots
// R15: Each slot result held until next conversion
`timescale 1ns/1ns
`include "mas_defs.vh"
module mas_sched #(
  parameter CONV = 2'h0,
  parameter NSLOT = 16,
  parameter CONV_CYCLES = 8'd16,
  parameter RES_W = 12
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Trigger pulses
  input wire pfc_timebase_trigger_a,
  input wire pfc_timebase_trigger_b,
  input wire phase2_timebase_trigger_a,
  input wire phase2_timebase_trigger_b,
  input wire primary_leg_trigger_a,
  input wire cpu_timer2_trigger,
  // Converter core
  output reg conv_start,
  output reg [4:0] conv_channel,
  input wire conv_done,
  input wire [RES_W-1:0] conv_data,
  // Result readback
  input wire [3:0] rd_slot,
  output reg [RES_W-1:0] rd_data,
  // Sample record stream
  output wire rec_valid,
  input wire rec_ready,
  output wire [RES_W+3:0] rec_data,
  // Status
  output reg [NSLOT-1:0] pending,
  output reg overrun
);
  // ----------------------------------------
  // Slot map
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_PUSH = 2'h2;
  reg [2:0] slot_trg [0:NSLOT-1];
  reg [4:0] slot_ch [0:NSLOT-1];
  reg [RES_W-1:0] res_q [0:NSLOT-1];
  reg [NSLOT-1:0] fire;
  reg [NSLOT-1:0] pend_d;
  reg [1:0] st_q;
  reg [3:0] cur_q;
  reg [3:0] last_q;
  reg [3:0] pick;
  reg found;
  reg [7:0] tmo_q;
  reg [4:0] k;
  reg [3:0] idx;
  reg fifo_in_valid;
  wire fifo_in_ready;
  // R14: tank currents have no channel entry at all
  integer i;
  // Own loop index per process, no shared driver
  integer f;
  integer r;
  always @* begin
    for (i = 0; i < NSLOT; i = i + 1) begin
      slot_trg[i] = `MAS_TRG_NONE;
      slot_ch[i] = 5'h00;
    end
    case (CONV)
      `MAS_CONV_A: begin
        // R5: phase-one current twice per period
        slot_ch[0] = `MAS_CH_A2;
        slot_trg[0] = `MAS_TRG_PFC_A;
        slot_ch[1] = `MAS_CH_A2;
        slot_trg[1] = `MAS_TRG_PFC_B;
        // R8: secondary current eleven slots
        for (i = 2; i <= 12; i = i + 1) begin
          slot_ch[i] = `MAS_CH_A5;
          slot_trg[i] = (i <= 7) ? `MAS_TRG_PFC_A : `MAS_TRG_PFC_B;
        end
        // R11: primary current single slot
        slot_ch[13] = `MAS_CH_A9;
        slot_trg[13] = `MAS_TRG_PRIM_A;
        // R13: low-rate line voltage and temperature
        slot_ch[14] = `MAS_CH_A4;
        slot_trg[14] = `MAS_TRG_TMR2;
        slot_ch[15] = `MAS_CH_A11;
        slot_trg[15] = `MAS_TRG_TMR2;
      end
      `MAS_CONV_B: begin
        // R6: phase-two current twice per period
        slot_ch[0] = `MAS_CH_B12;
        slot_trg[0] = `MAS_TRG_PFC_A;
        slot_ch[1] = `MAS_CH_B12;
        slot_trg[1] = `MAS_TRG_PFC_B;
        // R10: bus voltage on both PWM pairs
        slot_ch[2] = `MAS_CH_B4;
        slot_trg[2] = `MAS_TRG_PFC_A;
        slot_ch[3] = `MAS_CH_B4;
        slot_trg[3] = `MAS_TRG_PFC_B;
        slot_ch[4] = `MAS_CH_B4;
        slot_trg[4] = `MAS_TRG_PH2_A;
        slot_ch[5] = `MAS_CH_B4;
        slot_trg[5] = `MAS_TRG_PH2_B;
        // R12: low-rate slots on timer after fast ones
        slot_ch[10] = `MAS_CH_B2;
        slot_trg[10] = `MAS_TRG_TMR2;
        slot_ch[11] = `MAS_CH_B5;
        slot_trg[11] = `MAS_TRG_TMR2;
      end
      default: begin
        // R7: line voltage twice per period
        slot_ch[0] = `MAS_CH_C7;
        slot_trg[0] = `MAS_TRG_PFC_A;
        slot_ch[1] = `MAS_CH_C7;
        slot_trg[1] = `MAS_TRG_PFC_B;
        // R9: secondary voltage all on trigger A
        for (i = 2; i <= 12; i = i + 1) begin
          slot_ch[i] = `MAS_CH_C11;
          slot_trg[i] = `MAS_TRG_PFC_A;
        end
        // R12: low-rate slots on timer after fast ones
        slot_ch[14] = `MAS_CH_C10;
        slot_trg[14] = `MAS_TRG_TMR2;
        slot_ch[15] = `MAS_CH_C11;
        slot_trg[15] = `MAS_TRG_TMR2;
      end
    endcase
  end

  // ----------------------------------------
  // Trigger to slot firing
  // ----------------------------------------
  // R4: A and B events are separate pulses from the partner
  always @* begin
    for (f = 0; f < NSLOT; f = f + 1) begin
      case (slot_trg[f])
        `MAS_TRG_PFC_A: fire[f] = pfc_timebase_trigger_a;
        `MAS_TRG_PFC_B: fire[f] = pfc_timebase_trigger_b;
        `MAS_TRG_PH2_A: fire[f] = phase2_timebase_trigger_a;
        `MAS_TRG_PH2_B: fire[f] = phase2_timebase_trigger_b;
        `MAS_TRG_PRIM_A: fire[f] = primary_leg_trigger_a;
        `MAS_TRG_TMR2: fire[f] = cpu_timer2_trigger;
        default: fire[f] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Round robin pick after the last slot served
  // ----------------------------------------
  // R3: search ascending from slot after the last one
  always @* begin
    pick = 4'h0;
    found = 1'b0;
    idx = 4'h0;
    for (k = 5'd1; k <= 5'd16; k = k + 5'd1) begin
      idx = last_q + k[3:0];
      if (!found && pending[idx]) begin
        pick = idx;
        found = 1'b1;
      end
    end
  end

  // R2: set wins over the clear of the slot served
  always @* begin
    pend_d = pending | fire;
    if (st_q == ST_IDLE && found) begin
      pend_d[pick] = fire[pick];
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // R1: all state local to this instance
  always @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cur_q <= 4'h0;
      last_q <= 4'hf;
      pending <= {NSLOT{1'b0}};
      overrun <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 5'h00;
      tmo_q <= 8'h00;
      fifo_in_valid <= 1'b0;
    end else begin
      pending <= pend_d;
      conv_start <= 1'b0;
      // Refire of a slot still pending loses a sample
      if ((fire & pending) != {NSLOT{1'b0}}) begin
        overrun <= 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          if (found) begin
            cur_q <= pick;
            last_q <= pick;
            conv_channel <= slot_ch[pick];
            conv_start <= 1'b1;
            tmo_q <= CONV_CYCLES;
            st_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          // Core hang guard so the sequencer never wedges
          if (conv_done || tmo_q == 8'h00) begin
            fifo_in_valid <= 1'b1;
            st_q <= ST_PUSH;
          end else begin
            tmo_q <= tmo_q - 8'h01;
          end
        end
        ST_PUSH: begin
          // Full FIFO stalls the sequencer
          if (fifo_in_ready) begin
            fifo_in_valid <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Per-slot results
  // ----------------------------------------
  reg [RES_W-1:0] cap_q;
  // R15: result kept until the slot converts again
  always @(posedge sys_clk) begin
    if (rst) begin
      for (r = 0; r < NSLOT; r = r + 1) begin
        res_q[r] <= `MAS_RESULT_RST;
      end
      cap_q <= `MAS_RESULT_RST;
      rd_data <= `MAS_RESULT_RST;
    end else begin
      if (st_q == ST_CONV && conv_done) begin
        res_q[cur_q] <= conv_data;
        cap_q <= conv_data;
      end
      rd_data <= res_q[rd_slot];
    end
  end

  mas_fifo #(
    .WIDTH(RES_W + 4),
    .DEPTH(`MAS_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({cur_q, cap_q}),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data)
  );
endmodule // mas_sched

// ===== tb/mas_sched_properties.sv
// Assertions for one converter slot scheduler
`timescale 1ns/1ns
module mas_sched_chk #(
  parameter CONV = 2'h0,
  parameter NSLOT = 16,
  parameter RES_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Triggers
  input wire logic pfc_timebase_trigger_a,
  input wire logic pfc_timebase_trigger_b,
  input wire logic cpu_timer2_trigger,
  // Converter and stream
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic rec_valid,
  input wire logic rec_ready,
  input wire logic [RES_W+3:0] rec_data,
  // Status
  input wire logic [NSLOT-1:0] pending,
  input wire logic overrun
);
  // ----------------
  // Slot masks per source
  // ----------------
  localparam [NSLOT-1:0] MPA = CONV == 0 ? 16'h00fd : CONV == 1 ? 16'h0005 : 16'h1ffd;
  localparam [NSLOT-1:0] MPB = CONV == 0 ? 16'h1f02 : CONV == 1 ? 16'h000a : 16'h0002;
  localparam [NSLOT-1:0] MTM = CONV == 1 ? 16'h0c00 : 16'hc000;
  localparam [NSLOT-1:0] MAL = CONV == 0 ? 16'hffff : CONV == 1 ? 16'h0c3f : 16'hdfff;
  logic busy_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Busy from start to done; timeout path not modelled
  always @(posedge sys_clk) begin
    if (rst) busy_q <= 1'b0;
    else if (conv_start) busy_q <= 1'b1;
    else if (conv_done) busy_q <= 1'b0;
  end
  sequence s_rec_up; ##[1:5] rec_valid; endsequence
  sequence s_pulse; conv_start ##1 !conv_start; endsequence
  property p_pfc_a; pfc_timebase_trigger_a |=> (pending & MPA) == MPA; endproperty
  a_pfc_a: assert property (p_pfc_a) else $error("pfc a slots");
  property p_pfc_b; pfc_timebase_trigger_b |=> (pending & MPB) == MPB; endproperty
  a_pfc_b: assert property (p_pfc_b) else $error("pfc b slots");
  property p_tmr; cpu_timer2_trigger |=> (pending & MTM) == MTM; endproperty
  a_tmr: assert property (p_tmr) else $error("timer slots");
  property p_stray; (pending & ~MAL) == 16'h0000; endproperty
  a_stray: assert property (p_stray) else $error("unmapped slot pending");
  property p_one; conv_start |-> !busy_q; endproperty
  a_one: assert property (p_one) else $error("start while busy");
  property p_cause; conv_start |-> $past(pending) != 16'h0000; endproperty
  a_cause: assert property (p_cause) else $error("start without pending");
  property p_pulse; conv_start |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("start not a pulse");
  property p_rec; conv_done |-> s_rec_up; endproperty
  a_rec: assert property (p_rec) else $error("no record after done");
  property p_hold; rec_valid && !rec_ready |=> rec_valid && $stable(rec_data); endproperty
  a_hold: assert property (p_hold) else $error("record dropped");
  property p_ovr; overrun |=> overrun; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun cleared");
endmodule // mas_sched_chk
bind mas_sched mas_sched_chk #(.CONV(CONV), .NSLOT(NSLOT), .RES_W(RES_W)) i_chk (
  .sys_clk, .rst, .pfc_timebase_trigger_a, .pfc_timebase_trigger_b, .cpu_timer2_trigger,
  .conv_start, .conv_done, .rec_valid, .rec_ready, .rec_data, .pending, .overrun);

// ===== tb/mas_sched_test.sv
// Self-checking bench for three converter slot schedulers
`timescale 1ns/1ns
`include "mas_defs.vh"
module mas_sched_test;
  // ----------------
  // Signals and scoreboards
  // ----------------
  logic sys_clk, rst, hold;
  logic [5:0] req;
  wire [5:0] trg;
  logic [3:0] rd_s;
  logic st[3], dn[3], rv[3], rdy[3], ovr[3];
  logic [4:0] ch[3];
  logic [11:0] dat[3], rd_d[3];
  logic [15:0] rec[3], pend[3];
  logic [11:0] res_mem[3][16];
  logic [15:0] rec_q[3][$];
  int ord_q[3][$];
  int last[3];
  int fails = 0, tests_run = 0, cyc = 0;
  mas_trig_gen i_trig (.sys_clk(sys_clk), .rst(rst), .req(req), .trg(trg));
  function automatic logic [7:0] slot_map(input int c, input int s);
    logic [2:0] t;
    logic [4:0] h;
    if (c == 0) begin
      h = s < 2 ? `MAS_CH_A2 : s < 13 ? `MAS_CH_A5 : s == 13 ? `MAS_CH_A9 :
          s == 14 ? `MAS_CH_A4 : `MAS_CH_A11;
      t = s > 13 ? `MAS_TRG_TMR2 : s == 13 ? `MAS_TRG_PRIM_A :
          (s == 0 || (s > 1 && s < 8)) ? `MAS_TRG_PFC_A : `MAS_TRG_PFC_B;
    end else if (c == 1) begin
      h = s < 2 ? `MAS_CH_B12 : s < 6 ? `MAS_CH_B4 : s == 10 ? `MAS_CH_B2 : `MAS_CH_B5;
      t = s < 6 ? 3'(1 + s % 2 + (s > 3 ? 2 : 0)) : (s == 10 || s == 11) ? `MAS_TRG_TMR2 : 3'h0;
    end else begin
      h = s < 2 ? `MAS_CH_C7 : s == 14 ? `MAS_CH_C10 : `MAS_CH_C11;
      t = s == 1 ? `MAS_TRG_PFC_B : s < 13 ? `MAS_TRG_PFC_A : s > 13 ? `MAS_TRG_TMR2 : 3'h0;
    end
    return {t, h};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Expected order: mapped slots ascending after the last one served
  task automatic fire(input logic [5:0] m, input bit again);
    logic [7:0] e;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 16; i++) begin
        e = slot_map(k, (last[k] + 1 + i) % 16);
        if (e[7:5] != 3'h0 && m[e[7:5] - 3'h1]) ord_q[k].push_back((last[k] + 1 + i) % 16);
      end
      if (again && ord_q[k].size() > 0) ord_q[k].push_back(ord_q[k][0]);
    end
    for (int j = 0; j < 6; j++) begin
      if (m[j]) begin
        @(negedge sys_clk) req = 6'h01 << j;
        @(negedge sys_clk) req = 6'h00;
      end
    end
    if (again) begin
      repeat (2) @(negedge sys_clk);
      @(negedge sys_clk) req = m;
      @(negedge sys_clk) req = 6'h00;
    end
  endtask
  task automatic drain();
    while (ord_q[0].size() + ord_q[1].size() + ord_q[2].size() + rec_q[0].size() +
           rec_q[1].size() + rec_q[2].size() > 0) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
  endtask
  for (genvar k = 0; k < 3; k++) begin : g_conv
    int sl, wn = 0;
    logic [4:0] chl;
    logic [6:0] sq = 7'h00;
    logic [7:0] e;
    mas_sched #(.CONV(2'(k))) i_dut (
      .sys_clk(sys_clk), .rst(rst), .pfc_timebase_trigger_a(trg[0]),
      .pfc_timebase_trigger_b(trg[1]), .phase2_timebase_trigger_a(trg[2]),
      .phase2_timebase_trigger_b(trg[3]), .primary_leg_trigger_a(trg[4]),
      .cpu_timer2_trigger(trg[5]), .conv_start(st[k]), .conv_channel(ch[k]),
      .conv_done(dn[k]), .conv_data(dat[k]), .rd_slot(rd_s), .rd_data(rd_d[k]),
      .rec_valid(rv[k]), .rec_ready(rdy[k]), .rec_data(rec[k]), .pending(pend[k]),
      .overrun(ovr[k]));
    always @(posedge sys_clk) begin
      if (!rst && st[k] === 1'b1) begin
        sl = ord_q[k].size() > 0 ? ord_q[k].pop_front() : 16;
        e = slot_map(k, sl);
        check(16'(sl < 16), 16'h0001);
        check(16'(ch[k]), 16'(e[4:0]));
        chl = ch[k];
        sq = sq + 7'h01;
        last[k] = sl;
        rec_q[k].push_back({sl[3:0], e[4:0], sq});
        res_mem[k][sl[3:0]] = {e[4:0], sq};
        wn = 3 + $urandom % 6;
      end
      if (!rst && rv[k] === 1'b1 && rdy[k] === 1'b1)
        check(rec[k], rec_q[k].pop_front());
    end
    // Core model answers with the channel it was given
    always @(negedge sys_clk) begin
      dn[k] = 1'b0;
      rdy[k] = hold ? 1'b0 : 1'($urandom);
      if (wn > 0) begin
        wn = wn - 1;
        dn[k] = wn == 0;
        dat[k] = {chl, sq};
      end
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    hold = 1'b1;
    req = 6'h00;
    rd_s = 4'h0;
    for (int k = 0; k < 3; k++) begin
      dn[k] = 1'b0;
      dat[k] = 12'h000;
      rdy[k] = 1'b0;
      last[k] = -1;
      for (int s = 0; s < 16; s++) res_mem[k][s] = `MAS_RESULT_RST;
    end
    void'($urandom(20));
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    for (int k = 0; k < 3; k++) check(pend[k], 16'h0000);
    // All sources, far side stalled
    fire(6'h3f, 1'b0);
    repeat (300) @(negedge sys_clk);
    for (int k = 0; k < 3; k++) check(16'(rv[k]), 16'h0001);
    check(pend[0], 16'h0000);
    hold = 1'b0;
    drain();
    $display("test fill done");
    for (int j = 0; j < 18; j++) begin
      fire(6'h01 << (j < 6 ? j : $urandom % 6), 1'b0);
      drain();
      for (int k = 0; k < 3; k++) check(16'(ovr[k]), 16'h0000);
    end
    $display("test sources done");
    fire(6'h20, 1'b1);
    drain();
    for (int k = 0; k < 3; k++) check(16'(ovr[k]), 16'h0001);
    $display("test refire done");
    for (int s = 0; s < 16; s++) begin
      @(negedge sys_clk) rd_s = 4'(s);
      @(negedge sys_clk);
      for (int k = 0; k < 3; k++) check(16'(rd_d[k]), 16'(res_mem[k][s]));
    end
    $display("test readback done");
    complete_run();
  end
endmodule // mas_sched_test

// ===== tb/mas_trig_gen.sv
// Trigger pulse source for time bases and timer
`timescale 1ns/1ns
module mas_trig_gen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fire request and pulses
  input wire logic [5:0] req,
  output logic [5:0] trg
);
  always @(posedge sys_clk) begin
    trg <= rst ? 6'h00 : req;
  end
endmodule // mas_trig_gen
